// *** src/hsc_defs.vh ***
`ifndef HSC_DEFS_VH
`define HSC_DEFS_VH
// Clock period in picoseconds (200 MHz)
`define HSC_CLK_PS 5000
// Enable (initialization) time, typical, in ns
`define HSC_T_EN_NS 110000
`define HSC_T_EN_CYC ((`HSC_T_EN_NS * 1000) / `HSC_CLK_PS)
// Bus idle time to connect, typical, in ns (window 50..200 us)
`define HSC_T_IDLE_NS 105000
`define HSC_T_IDLE_MIN_NS 50000
`define HSC_T_IDLE_MAX_NS 200000
`define HSC_T_IDLE_CYC ((`HSC_T_IDLE_NS * 1000) / `HSC_CLK_PS)
// Delay from STOP to connect/ready, typical, in ns
`define HSC_T_STOP_NS 1200
`define HSC_T_STOP_CYC ((`HSC_T_STOP_NS * 1000) / `HSC_CLK_PS)
// Accelerator pulse length after a qualified rising edge, in ns
`define HSC_T_ACC_NS 100
`define HSC_T_ACC_CYC ((`HSC_T_ACC_NS * 1000) / `HSC_CLK_PS)
// Controller states
`define HSC_ST_OFF 2'h0
`define HSC_ST_INIT 2'h1
`define HSC_ST_WAIT 2'h2
`define HSC_ST_CONN 2'h3
`endif

// *** src/hsc_sync.v ***
// Two-flop synchroniser for a group of asynchronous line levels
module hsc_sync #(
  parameter W = 4,
  parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
  input wire clk,
  input wire resetn,
  input wire ce,
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);
  reg [W-1:0] stage1;

  // Each bit resets to its own idle level, so release shows no false edge
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= RST_VAL;
      sync_out <= RST_VAL;
    end else if (ce) begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// *** src/hsc_top.v ***
`include "hsc_defs.vh"

module hsc_top #(
  parameter EN_CYC = `HSC_T_EN_CYC,
  parameter IDLE_CYC = `HSC_T_IDLE_CYC,
  parameter STOP_CYC = `HSC_T_STOP_CYC,
  parameter ACC_CYC = `HSC_T_ACC_CYC
) (
  input wire clk,
  input wire resetn,
  input wire ce,
  input wire power_good,
  input wire enable,
  input wire backplane_data_in,
  output reg backplane_data_out,
  output reg backplane_data_oe,
  input wire backplane_clock_in,
  output reg backplane_clock_out,
  output reg backplane_clock_oe,
  input wire card_data_in,
  output reg card_data_out,
  output reg card_data_oe,
  input wire card_clock_in,
  output reg card_clock_out,
  output reg card_clock_oe,
  output reg [3:0] precharge_on,
  output reg [3:0] accel_on,
  output reg ready_out,
  output reg ready_oe,
  output reg low_power
);
  // Line order in vectors: 0 backplane_data, 1 card_data, 2 backplane_clock, 3 card_clock
  wire [5:0] raw_in;
  wire [5:0] sync_in;
  wire [3:0] line;
  wire pg;
  wire en;
  reg [3:0] line_q;
  reg [1:0] state;
  reg [1:0] next_state;
  reg [17:0] init_cnt;
  reg [17:0] idle_cnt;
  reg [8:0] stop_cnt;
  reg stop_pend;
  reg [3:0] drive_low;
  reg [3:0] next_drive_low;
  reg [3:0] own_d1;
  reg [3:0] own_d2;
  wire [3:0] own;
  reg [7:0] acc_cnt [0:3];
  wire all_high;
  wire stop_seen;
  wire conn;

  assign raw_in = {power_good, enable, card_clock_in, backplane_clock_in,
                   card_data_in, backplane_data_in};

  // All pins arrive from outside this clock domain; supply and enable start
  // low so a release of reset never looks like a power-up
  hsc_sync #(.W(6), .RST_VAL(6'h0f)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .async_in(raw_in),
    .sync_out(sync_in)
  );

  assign line = sync_in[3:0];
  assign en = sync_in[4];
  assign pg = sync_in[5];
  assign all_high = &line;
  // Next state, so pins and accelerators let go on the edge that leaves the join
  assign conn = (next_state == `HSC_ST_CONN);
  assign own = drive_low | own_d1 | own_d2;
  assign stop_seen = !line_q[0] && line[0] && line_q[2] && line[2];

  // Previous line levels for edge detection
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      line_q <= 4'hf;
    end else if (ce) begin
      line_q <= line;
    end
  end

  // Connection state machine
  always @* begin
    next_state = state;
    case (state)
      `HSC_ST_OFF: begin
        // Low enable always forces OFF, so a level test covers both start cases
        if (pg && en) begin
          next_state = `HSC_ST_INIT;
        end
      end
      `HSC_ST_INIT: begin
        if (init_cnt >= EN_CYC - 1) begin
          next_state = `HSC_ST_WAIT;
        end
      end
      `HSC_ST_WAIT: begin
        if (all_high && (idle_cnt >= IDLE_CYC - 1)) begin
          next_state = `HSC_ST_CONN;
        end else if (stop_pend && all_high && (stop_cnt >= STOP_CYC - 1)) begin
          next_state = `HSC_ST_CONN;
        end
      end
      `HSC_ST_CONN: next_state = `HSC_ST_CONN;
      default: next_state = `HSC_ST_OFF;
    endcase
    if (!pg || !en) begin
      next_state = `HSC_ST_OFF;
    end
  end

  // State, init timer, idle counter and STOP delay
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= `HSC_ST_OFF;
      init_cnt <= 18'h0_0000;
      idle_cnt <= 18'h0_0000;
      stop_cnt <= 9'h000;
      stop_pend <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      if (state == `HSC_ST_INIT) begin
        init_cnt <= init_cnt + 18'h0_0001;
      end else begin
        init_cnt <= 18'h0_0000;
      end
      // Detector only runs once armed; any low restarts the count
      if (state != `HSC_ST_WAIT || !all_high) begin
        idle_cnt <= 18'h0_0000;
      end else if (idle_cnt != 18'h3_ffff) begin
        idle_cnt <= idle_cnt + 18'h0_0001;
      end
      // A STOP is only useful while all lines stay high afterwards
      if (state != `HSC_ST_WAIT || !all_high) begin
        stop_pend <= 1'b0;
        stop_cnt <= 9'h000;
      end else if (stop_seen && line[1] && line[3]) begin
        stop_pend <= 1'b1;
        stop_cnt <= 9'h000;
      end else if (stop_pend && stop_cnt != 9'h1ff) begin
        stop_cnt <= stop_cnt + 9'h001;
      end
    end
  end

  // Low propagation per pair; a side is pulled only while the partner has an
  // external low, so our own drive never holds itself (the pair releases
  // only when all outside drivers let go)
  // A synchronised low stands for a qualified falling edge. Only one side of a
  // pair is ever pulled; limitation: a side we pull cannot show an outside low
  always @* begin
    next_drive_low = 4'h0;
    if (conn) begin
      next_drive_low[1] = !line[0] && (drive_low[1] || !own[0]);
      next_drive_low[0] = !line[1] && (drive_low[0] || !own[1]) && !next_drive_low[1];
      next_drive_low[3] = !line[2] && (drive_low[3] || !own[2]);
      next_drive_low[2] = !line[3] && (drive_low[2] || !own[3]) && !next_drive_low[3];
    end
  end

  // Drive history spans the synchroniser lag, so a line still reading our own
  // low after release is not taken for an outside low and bounced back
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      drive_low <= 4'h0;
      own_d1 <= 4'h0;
      own_d2 <= 4'h0;
    end else if (ce) begin
      drive_low <= next_drive_low;
      own_d1 <= drive_low;
      own_d2 <= own_d1;
    end
  end

  // Rise accelerator per line: a clean rising edge after a low fires a
  // short pulse; digital edges stand in for the analog slew and threshold
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_acc
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          acc_cnt[gi] <= 8'h00;
        end else if (ce) begin
          if (!conn || !line[gi]) begin
            acc_cnt[gi] <= 8'h00;
          end else if (!line_q[gi] && !next_drive_low[gi]) begin
            acc_cnt[gi] <= ACC_CYC[7:0];
          end else if (acc_cnt[gi] != 8'h00) begin
            acc_cnt[gi] <= acc_cnt[gi] - 8'h01;
          end
        end
      end
    end
  endgenerate

  // Registered pin outputs; open-drain pins drive only low
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      backplane_data_out <= 1'b0;
      backplane_clock_out <= 1'b0;
      card_data_out <= 1'b0;
      card_clock_out <= 1'b0;
      backplane_data_oe <= 1'b0;
      card_data_oe <= 1'b0;
      backplane_clock_oe <= 1'b0;
      card_clock_oe <= 1'b0;
      precharge_on <= 4'h0;
      accel_on <= 4'h0;
      ready_out <= 1'b0;
      ready_oe <= 1'b1;
      low_power <= 1'b1;
    end else if (ce) begin
      backplane_data_oe <= next_drive_low[0];
      card_data_oe <= next_drive_low[1];
      backplane_clock_oe <= next_drive_low[2];
      card_clock_oe <= next_drive_low[3];
      precharge_on <= (next_state == `HSC_ST_INIT || next_state == `HSC_ST_WAIT) ?
                      4'hf : 4'h0;
      accel_on[0] <= conn && (acc_cnt[0] != 8'h00);
      accel_on[1] <= conn && (acc_cnt[1] != 8'h00);
      accel_on[2] <= conn && (acc_cnt[2] != 8'h00);
      accel_on[3] <= conn && (acc_cnt[3] != 8'h00);
      ready_oe <= (next_state != `HSC_ST_CONN);
      low_power <= (next_state == `HSC_ST_OFF);
    end
  end
endmodule

// *** dv/hsc_checker.sv ***
module hsc_checker (
  input wire clk,
  input wire resetn,
  input wire enable,
  input wire backplane_data_in,
  input wire card_data_in,
  input wire backplane_clock_in,
  input wire card_clock_in,
  input wire backplane_data_oe,
  input wire card_data_oe,
  input wire backplane_clock_oe,
  input wire card_clock_oe,
  input wire backplane_data_out,
  input wire card_data_out,
  input wire backplane_clock_out,
  input wire card_clock_out,
  input wire ready_out,
  input wire [3:0] precharge_on,
  input wire [3:0] accel_on,
  input wire ready_oe,
  input wire low_power
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // All four lines high; the joiner needs this before any connect
  wire all_hi = backplane_data_in & card_data_in & backplane_clock_in & card_clock_in;
  wire any_oe = backplane_data_oe | card_data_oe | backplane_clock_oe | card_clock_oe;
  a_off_quiet: assert property (
    low_power |-> !any_oe && accel_on == 4'h0 && precharge_on == 4'h0 && ready_oe)
    else $error("off state not quiet");
  a_init_pre: assert property ($fell(low_power) |-> precharge_on == 4'hf)
    else $error("precharge not on at start");
  a_init_hold: assert property ($fell(low_power) |-> ready_oe [*8])
    else $error("joined during start-up");
  a_conn_idle: assert property (
    $fell(ready_oe) |-> $past(all_hi, 2) && $past(all_hi, 3) && $past(all_hi, 4))
    else $error("joined with a line low");
  a_conn_pre: assert property (!ready_oe |-> precharge_on == 4'h0)
    else $error("precharge on while joined");
  a_prop_data: assert property (
    $fell(card_data_in) && !ready_oe && !card_data_oe
    |-> ##[2:4] (backplane_data_oe || ready_oe))
    else $error("data low not passed");
  a_prop_clock: assert property (
    $fell(backplane_clock_in) && !ready_oe && !backplane_clock_oe
    |-> ##[2:4] (card_clock_oe || ready_oe))
    else $error("clock low not passed");
  // Release is bounded so a stuck pull-down shows up
  a_data_release: assert property (
    $rose(card_data_in) && backplane_data_oe |-> ##[1:4] !backplane_data_oe)
    else $error("pull-down not released");
  a_ready_fall: assert property ($fell(enable) |-> ##[1:4] ready_oe)
    else $error("ready late after disable");
  // Open-drain pins may only ever pull low, never drive high
  a_pins_low: assert property (
    !(backplane_data_out | card_data_out | backplane_clock_out | card_clock_out | ready_out))
    else $error("open-drain pin driven high");
endmodule

bind hsc_top hsc_checker u_chk (.clk(clk), .resetn(resetn), .enable(enable),
  .backplane_data_in(backplane_data_in), .card_data_in(card_data_in),
  .backplane_clock_in(backplane_clock_in), .card_clock_in(card_clock_in),
  .backplane_data_oe(backplane_data_oe), .card_data_oe(card_data_oe),
  .backplane_clock_oe(backplane_clock_oe), .card_clock_oe(card_clock_oe),
  .precharge_on(precharge_on), .accel_on(accel_on), .ready_oe(ready_oe),
  .backplane_data_out(backplane_data_out), .card_data_out(card_data_out),
  .backplane_clock_out(backplane_clock_out), .card_clock_out(card_clock_out),
  .ready_out(ready_out), .low_power(low_power));

// *** dv/hsc_bus_model.sv ***
module hsc_bus_model (
  input wire [3:0] dev_low,
  input wire [3:0] ext_low,
  output wire [3:0] line
);
  // Pull-ups: a released line goes high, never keeps a stale low
  assign line = ~(dev_low | ext_low);
endmodule

// *** dv/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0;
  logic resetn = 0;
  logic power_good = 0;
  logic enable = 1;
  logic [3:0] ext_low = 4'h0;
  wire [3:0] line;
  wire [3:0] oe;
  wire [3:0] pre_on;
  wire [3:0] acc_on;
  wire rdy_oe;
  wire low_pwr;
  int error_cnt = 0;
  int num_checks = 0;
  always #2.5 clk = ~clk;
  hsc_bus_model u_bus (.dev_low(oe), .ext_low(ext_low), .line(line));
  // Short counts keep the run small; expectations use the same values
  hsc_top #(.EN_CYC(20), .IDLE_CYC(30), .STOP_CYC(5), .ACC_CYC(4)) u_dut (
    .clk(clk), .resetn(resetn), .ce(1'b1), .power_good(power_good), .enable(enable),
    .backplane_data_in(line[0]), .backplane_data_out(), .backplane_data_oe(oe[0]),
    .backplane_clock_in(line[2]), .backplane_clock_out(), .backplane_clock_oe(oe[2]),
    .card_data_in(line[1]), .card_data_out(), .card_data_oe(oe[1]),
    .card_clock_in(line[3]), .card_clock_out(), .card_clock_oe(oe[3]),
    .precharge_on(pre_on), .accel_on(acc_on), .ready_out(), .ready_oe(rdy_oe),
    .low_power(low_pwr));
  task automatic chk(input string name, input logic [3:0] exp, input logic [3:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Bounded wait for the join; n is the cycles spent
  task automatic wait_rdy(input int lim, output int n);
    n = 0;
    while (rdy_oe !== 1'b0 && n < lim) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // A short low after start-up must restart the idle count
  task automatic t_powerup;
    int n;
    power_good = 1;
    cyc(4);
    chk("precharge", 4'hf, pre_on);
    cyc(36);
    ext_low = 4'h8;
    cyc(2);
    ext_low = 4'h0;
    wait_rdy(60, n);
    chk("idle span", 4'h1, {3'h0, n >= 29 && n <= 40});
    chk("precharge off", 4'h0, pre_on);
  endtask
  // Lows cross in both pairs, never back onto their source
  task automatic t_pass;
    logic [3:0] seen;
    seen = 4'h0;
    ext_low = 4'h2;
    cyc(5);
    chk("data oe", 4'h1, oe);
    cyc(10);
    chk("data held", 4'h1, oe);
    ext_low = 4'h0;
    repeat (8) begin
      cyc(1);
      seen = seen | acc_on;
    end
    chk("accel", 4'h1, {3'h0, seen != 4'h0});
    chk("released", 4'h0, oe);
    ext_low = 4'h4;
    cyc(5);
    chk("clock oe", 4'h8, oe);
    ext_low = 4'h0;
    cyc(6);
  endtask
  task automatic t_disable;
    enable = 0;
    cyc(4);
    chk("ready low", 4'h1, {3'h0, rdy_oe});
    chk("off", 4'h0, pre_on | acc_on | oe);
    chk("low power", 4'h1, {3'h0, low_pwr});
  endtask
  // Data held low blocks idle; link clock frames, then a stop joins fast
  task automatic t_stop;
    int n;
    ext_low = 4'h1;
    enable = 1;
    cyc(40);
    repeat (4) begin
      ext_low[2] = 1'b1;
      #24;
      ext_low[2] = 1'b0;
      #24;
    end
    ext_low = 4'h1;
    cyc(3);
    chk("no join", 4'h1, {3'h0, rdy_oe});
    ext_low = 4'h0;
    wait_rdy(20, n);
    chk("stop join", 4'h1, {3'h0, n <= 12});
  endtask
  // Watchdog sized well above the whole sequence
  initial begin
    #10000;
    error_cnt++;
    finish_test();
  end
  initial begin
    repeat (6) @(posedge clk);
    #1;
    resetn = 1;
    cyc(1);
    chk("low power at release", 4'h1, {3'h0, low_pwr});
    cyc(1);
    chk("off oe", 4'h0, oe);
    chk("not ready", 4'h1, {3'h0, rdy_oe});
    t_powerup();
    t_pass();
    t_disable();
    t_stop();
    finish_test();
  end
endmodule
